// ==== phy_timing_defines.svh ====
// register offsets, field positions and reset values of the timing override bank
`ifndef PHY_TIMING_DEFINES_SVH
`define PHY_TIMING_DEFINES_SVH

// indirect page that holds the bank
`define PAGE_TIMING 8'h00
// printed offsets are not multiples of four: these are register indices
`define IDX_CLK_PREPARE 8'h40
`define IDX_CLK_ZERO 8'h41
`define IDX_CLK_TRAIL 8'h42
`define IDX_CLK_POST 8'h43
`define IDX_HS_PREPARE 8'h44
`define IDX_FIRST 8'h40
`define IDX_LAST 8'h44
// register fields
`define OVR_BIT 7
`define VAL_MSB 6
`define VAL_LSB 0
// reset value of every register in the bank
`define TIMING_RESET 8'h00

`endif

// ==== phy_timing_pkg.sv ====
// types shared by the timing override bank
package phy_timing_pkg;

  // one timing register: override flag over a 7-bit value
  typedef struct packed {
    logic ovr;
    logic [6:0] val;
  } timing_reg_t;

  // the five timing parameters as the transmitter sees them
  typedef struct packed {
    logic [6:0] clk_prepare;
    logic [6:0] clk_zero;
    logic [6:0] clk_trail;
    logic [6:0] clk_post;
    logic [6:0] hs_prepare;
  } timing_set_t;

  // bus answer phases
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;

endpackage : phy_timing_pkg

// ==== csi_phy_timing_override_regs.sv ====
// timing override register bank with apb slave and timing outputs
`include "phy_timing_defines.svh"

// register map, one 8-bit register in the low byte of each 32-bit word:
//   index 0x40 (byte 0x100) clock-lane prepare
//   index 0x41 (byte 0x104) clock-lane zero
//   index 0x42 (byte 0x108) clock-lane trail
//   index 0x43 (byte 0x10C) clock-lane post
//   index 0x44 (byte 0x110) data-lane hs prepare
// bit 7 is the override flag, bits 6:0 the value; with the flag clear the
// value field is read-only and shows the figure being applied automatically.
//
// bus timing: the access phase is taken on its first edge and answered one
// cycle later, so every transfer has exactly one wait state. pready, prdata
// and pslverr stand for one cycle only. unmapped or misaligned addresses get
// pslverr and leave the bank untouched; a write with pstrb[0] low is dropped
// without an error because the register lives in byte lane 0.
//
// limitation: the auto figures arrive from the transmitter as a level input;
// a read with the flag clear returns the figure present at the access edge,
// so a figure that moves during a read is caught at that edge only.

// Behaviour
// R01 - clock prepare: auto unless flag, else programmed
// R02 - clock zero: auto unless flag, else programmed
// R03 - clock trail: bit 7 selects programmed field
// R04 - clock post: auto unless flag, else programmed
// R05 - hs prepare: auto unless flag, else programmed
// R06 - flag clear: value reads applied auto figure
// R07 - flag set: value field writable and readable
// R08 - reset clears every flag and value
// R09 - five registers at indices 0x40-0x44, flag bit 7
// R10 - writes without flag change nothing visible
module csi_phy_timing_override_regs
  import phy_timing_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [34:0] AUTO_TIMING,
  output logic [34:0] APPLIED_TIMING
);

  // index of one register in the bank
  function automatic logic [2:0] slot_of(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    slot_of = 3'(idx - `IDX_FIRST);
  endfunction : slot_of

  // override mux: the programmed value wins only while the flag is set
  function automatic logic [6:0] pick(input timing_reg_t r, input logic [6:0] auto_v);
    pick = r.ovr ? r.val : auto_v;
  endfunction : pick

  timing_reg_t regs_q [0:4];
  timing_reg_t regs_d [0:4];
  timing_set_t auto_set;
  timing_set_t applied_d;
  logic [6:0] auto_v [0:4];
  logic [6:0] applied_v [0:4];
  bus_state_t state_q;
  bus_state_t state_d;
  logic [31:0] prdata_d;
  logic pslverr_d;

  // address decode
  wire logic [7:0] reg_idx = PADDR[9:2];
  wire logic aligned = (PADDR[1:0] == 2'h0) && (PADDR[31:10] == 22'h0);
  wire logic hit = aligned && (reg_idx >= `IDX_FIRST) && (reg_idx <= `IDX_LAST); // R09
  wire logic [2:0] slot = slot_of(PADDR);
  wire logic access = PSEL && PENABLE && (state_q == BUS_IDLE);
  wire logic wr_en = access && PWRITE && hit && PSTRB[0];

  // unpack the auto figures; the transmitter logic outside computes them
  assign auto_set = AUTO_TIMING;
  assign auto_v[0] = auto_set.clk_prepare;
  assign auto_v[1] = auto_set.clk_zero;
  assign auto_v[2] = auto_set.clk_trail;
  assign auto_v[3] = auto_set.clk_post;
  assign auto_v[4] = auto_set.hs_prepare;

  // applied timing per parameter
  assign applied_v[0] = pick(regs_q[0], auto_v[0]); // R01
  assign applied_v[1] = pick(regs_q[1], auto_v[1]); // R02
  assign applied_v[2] = pick(regs_q[2], auto_v[2]); // R03
  assign applied_v[3] = pick(regs_q[3], auto_v[3]); // R04
  assign applied_v[4] = pick(regs_q[4], auto_v[4]); // R05
  assign applied_d = {applied_v[0], applied_v[1], applied_v[2], applied_v[3], applied_v[4]};

  // next value of one register: flag and value load in the same write
  function automatic timing_reg_t next_reg(input logic sel, input logic [31:0] wdata, input timing_reg_t cur);
    timing_reg_t nxt;
    nxt = cur;
    if (sel) begin
      nxt.ovr = wdata[`OVR_BIT];
      // a write with the flag clear zeroes the hidden value so a later override starts clean
      nxt.val = wdata[`OVR_BIT] ? wdata[`VAL_MSB:`VAL_LSB] : 7'h00; // R07 R10
    end
    next_reg = nxt;
  endfunction : next_reg

  // per-register write selects
  wire logic sel_clk_prepare = wr_en && (slot == 3'h0);
  wire logic sel_clk_zero = wr_en && (slot == 3'h1);
  wire logic sel_clk_trail = wr_en && (slot == 3'h2);
  wire logic sel_clk_post = wr_en && (slot == 3'h3);
  wire logic sel_hs_prepare = wr_en && (slot == 3'h4);

  // register next values
  assign regs_d[0] = next_reg(sel_clk_prepare, PWDATA, regs_q[0]); // R07 R10
  assign regs_d[1] = next_reg(sel_clk_zero, PWDATA, regs_q[1]); // R07 R10
  assign regs_d[2] = next_reg(sel_clk_trail, PWDATA, regs_q[2]); // R07 R10
  assign regs_d[3] = next_reg(sel_clk_post, PWDATA, regs_q[3]); // R07 R10
  assign regs_d[4] = next_reg(sel_hs_prepare, PWDATA, regs_q[4]); // R07 R10

  // read byte per register: with flag clear the field shows the auto figure being applied
  wire logic [7:0] rd_clk_prepare = {regs_q[0].ovr, applied_v[0]};
  wire logic [7:0] rd_clk_zero = {regs_q[1].ovr, applied_v[1]};
  wire logic [7:0] rd_clk_trail = {regs_q[2].ovr, applied_v[2]};
  wire logic [7:0] rd_clk_post = {regs_q[3].ovr, applied_v[3]};
  wire logic [7:0] rd_hs_prepare = {regs_q[4].ovr, applied_v[4]};
  // selection stays inside the bank; an index past the bank reads zero instead of x
  wire logic [7:0] rd_byte = (slot == 3'h0) ? rd_clk_prepare :
                             (slot == 3'h1) ? rd_clk_zero :
                             (slot == 3'h2) ? rd_clk_trail :
                             (slot == 3'h3) ? rd_clk_post :
                             (slot == 3'h4) ? rd_hs_prepare : 8'h00; // R06
  assign prdata_d = (access && !PWRITE && hit) ? {24'h0, rd_byte} : 32'h0;
  assign pslverr_d = access && !hit;
  assign state_d = access ? BUS_DONE : BUS_IDLE;

  // register storage
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 5; i++) begin
        regs_q[i] <= `TIMING_RESET; // R08
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // bus answer: one wait state so every output is a flop
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= BUS_IDLE;
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      state_q <= state_d;
      PREADY <= access;
      PRDATA <= prdata_d;
      PSLVERR <= pslverr_d;
    end
  end

  // timing outputs registered; one cycle of latency is harmless for static parameters
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      APPLIED_TIMING <= 35'h0;
    end else begin
      APPLIED_TIMING <= applied_d;
    end
  end

  // per-register views under the field names; a_prep_override and a_prep_auto through a_hs_override read these
  wire logic clk_prepare_override_flag = regs_q[0].ovr;
  wire logic [6:0] clk_prepare_value = regs_q[0].val;
  wire logic clk_zero_override_flag = regs_q[1].ovr;
  wire logic [6:0] clk_zero_value = regs_q[1].val;
  wire logic clk_trail_override_flag = regs_q[2].ovr;
  wire logic [6:0] clk_trail_value = regs_q[2].val;
  wire logic clk_post_override_flag = regs_q[3].ovr;
  wire logic [6:0] clk_post_value = regs_q[3].val;
  wire logic hs_prepare_override_flag = regs_q[4].ovr;
  wire logic [6:0] hs_prepare_value = regs_q[4].val;

  // whole bank flattened so one stability check covers every register
  wire logic [39:0] bank_flat = {regs_q[0], regs_q[1], regs_q[2], regs_q[3], regs_q[4]};

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_prep_override: assert property (clk_prepare_override_flag // R01
                                    |=> APPLIED_TIMING[34:28] == $past(clk_prepare_value))
    else $error("clock prepare override not applied");
  a_zero_override: assert property (regs_q[1].ovr |=> APPLIED_TIMING[27:21] == $past(regs_q[1].val)) // R02
    else $error("clock zero override not applied");
  a_trail_auto: assert property (!regs_q[2].ovr |=> APPLIED_TIMING[20:14] == $past(auto_v[2])) // R03
    else $error("clock trail auto not applied");
  a_post_override: assert property (regs_q[3].ovr |=> APPLIED_TIMING[13:7] == $past(regs_q[3].val)) // R04
    else $error("clock post override not applied");
  a_hs_auto: assert property (!regs_q[4].ovr |=> APPLIED_TIMING[6:0] == $past(auto_v[4])) // R05
    else $error("hs prepare auto not applied");
  a_read_auto: assert property (access && !PWRITE && hit && !regs_q[slot].ovr // R06
                                |=> PREADY && PRDATA[6:0] == $past(auto_v[slot]))
    else $error("auto value not returned on read");
  a_write_kept: assert property (wr_en && PWDATA[7] |=> regs_q[$past(slot)].val == $past(PWDATA[6:0])) // R07
    else $error("override value not stored");
  a_write_ignored: assert property (wr_en && !PWDATA[7] |=> regs_q[$past(slot)] == 8'h00) // R10
    else $error("value stored while flag clear");
  a_ready_once: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY) // R09
    else $error("apb answer timing wrong");
  a_reset_clear: assert property ($fell(RST) |-> regs_q[0] == 8'h00 && regs_q[4] == 8'h00) // R08
    else $error("bank not cleared by reset");

  c_override_write: cover property (wr_en && PWDATA[7]);
  c_auto_read: cover property (access && !PWRITE && hit && !regs_q[slot].ovr);
  c_unmapped: cover property (access && !hit);
  c_back_to_auto: cover property (wr_en && !PWDATA[`OVR_BIT]);
  c_strobe_off: cover property (access && PWRITE && hit && !PSTRB[0]);

  // clock prepare follows the auto figure while its flag is clear
  a_prep_auto: assert property (!clk_prepare_override_flag // R01
                                |=> APPLIED_TIMING[34:28] == $past(auto_v[0]))
    else $error("clock prepare auto not applied");

  // clock zero follows the auto figure while its flag is clear
  a_zero_auto: assert property (!clk_zero_override_flag // R02
                                |=> APPLIED_TIMING[27:21] == $past(auto_v[1]))
    else $error("clock zero auto not applied");

  // clock trail takes the programmed field while bit 7 is set
  a_trail_override: assert property (clk_trail_override_flag // R03
                                     |=> APPLIED_TIMING[20:14] == $past(clk_trail_value))
    else $error("clock trail override not applied");

  // clock post follows the auto figure while its flag is clear
  a_post_auto: assert property (!clk_post_override_flag // R04
                                |=> APPLIED_TIMING[13:7] == $past(auto_v[3]))
    else $error("clock post auto not applied");

  // hs prepare takes the programmed field while its flag is set
  a_hs_override: assert property (hs_prepare_override_flag // R05
                                  |=> APPLIED_TIMING[6:0] == $past(hs_prepare_value))
    else $error("hs prepare override not applied");

  // an override write reaches the timing outputs one edge after it is taken and is checked at the second edge
  a_override_out: assert property (wr_en && PWDATA[7] && (slot == 3'h0) // R01
                                   |=> ##1 APPLIED_TIMING[34:28] == $past(PWDATA[6:0], 2))
    else $error("override write did not reach the output");

  // with the flag set a read returns the stored value
  a_read_override: assert property (access && !PWRITE && hit && regs_q[slot].ovr // R07
                                    |=> PREADY && PRDATA[6:0] == $past(regs_q[slot].val))
    else $error("stored value not returned on read");

  // the flag reads back in bit 7
  a_read_flag: assert property (access && !PWRITE && hit // R09
                                |=> PRDATA[7] == $past(regs_q[slot].ovr))
    else $error("flag not returned on read");

  // a write stores the written flag
  a_flag_write: assert property (wr_en // R07
                                 |=> regs_q[$past(slot)].ovr == $past(PWDATA[7]))
    else $error("flag not stored");

  // unmapped or misaligned access: error, zero data
  a_error_answer: assert property (access && !hit // R09
                                   |=> PREADY && PSLVERR && PRDATA == 32'h0)
    else $error("refused access answered wrongly");

  // a refused access leaves the bank untouched
  a_error_no_write: assert property (access && !hit // R09
                                     |=> $stable(bank_flat))
    else $error("refused access changed the bank");

  // misaligned addresses are always refused
  a_misaligned_error: assert property (access && (PADDR[1:0] != 2'h0) // R09
                                       |=> PSLVERR)
    else $error("misaligned access not refused");

  // a write with byte lane 0 off is dropped
  a_strobe_off: assert property (access && PWRITE && hit && !PSTRB[0] // R07
                                 |=> $stable(bank_flat))
    else $error("write without lane 0 changed the bank");

  // mapped accesses answer without error
  a_hit_no_error: assert property (access && hit // R09
                                   |=> PREADY && !PSLVERR)
    else $error("mapped access answered with error");

  // writes return zero read data
  a_write_no_data: assert property (access && PWRITE // R09
                                    |=> PRDATA == 32'h0)
    else $error("write returned read data");

  // only the low byte of read data carries anything
  a_upper_zero: assert property (PREADY // R09
                                 |-> PRDATA[31:8] == 24'h0)
    else $error("upper read data not zero");

  // no answer without a request
  a_no_stray_ready: assert property (!(PSEL && PENABLE) // R09
                                     |=> !PREADY)
    else $error("pready without a request");

  // pready stands one cycle only
  a_ready_pulse: assert property (PREADY // R09
                                  |=> !PREADY)
    else $error("pready held too long");

  // outputs stay quiet between answers
  a_quiet_idle: assert property (!PREADY // R09
                                 |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("read data or error outside an answer");

  // answer phase always returns to idle
  a_state_return: assert property (state_q == BUS_DONE // R09
                                   |=> state_q == BUS_IDLE)
    else $error("bus answer phase stuck");

  // no second write in the answer cycle
  a_done_no_write: assert property (state_q == BUS_DONE // R09
                                    |-> !wr_en)
    else $error("write taken in the answer cycle");

  // reads never change the bank
  a_read_no_change: assert property (access && !PWRITE // R06
                                     |=> $stable(bank_flat))
    else $error("read changed the bank");

  // nothing but a taken write changes the bank
  a_bank_quiet: assert property (!wr_en // R10
                                 |=> $stable(bank_flat))
    else $error("bank changed without a write");

  // outputs come out of reset at zero
  a_reset_outputs: assert property ($fell(RST) // R08
                                    |-> !PREADY && !PSLVERR && PRDATA == 32'h0 && APPLIED_TIMING == 35'h0)
    else $error("outputs not cleared by reset");

endmodule : csi_phy_timing_override_regs

// ==== csi_phy_timing_override_regs_tb.sv ====
// self-checking bench for the timing override register bank
`include "phy_timing_defines.svh"
module csi_phy_timing_override_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_timing_pkg::*;
  logic CLK_SYS = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, rd;
  logic [3:0] PSTRB = 4'h0;
  logic PREADY, PSLVERR, er;
  logic [34:0] AUTO_TIMING = 35'h0, APPLIED_TIMING, exp_app;
  int n_mismatch = 0, n_checks = 0;
  csi_phy_timing_override_regs u_csi_phy_timing_override_regs (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .AUTO_TIMING(AUTO_TIMING), .APPLIED_TIMING(APPLIED_TIMING));
  // 200 MHz system clock
  always #2.5 CLK_SYS = ~CLK_SYS;
  task chk(input string nm, input logic [34:0] e, input logic [34:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at a rising edge, answer taken at that edge
  task apb(input logic w, input int idx, input logic [31:0] d, input logic [31:0] a_raw = 32'h0,
           input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= (a_raw != 0) ? a_raw : (`IDX_FIRST + idx) * 4;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 35'h1, 35'h0);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  function automatic logic [31:0] autoval(input int i);
    return {25'h0, AUTO_TIMING[34-7*i -: 7]};
  endfunction : autoval
  task t_reset();
    chk("applied after reset", AUTO_TIMING, APPLIED_TIMING);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, i, 32'h0);
      chk("reset read", autoval(i), rd);
      chk("reset read err", 35'h0, er);
    end
  endtask : t_reset
  task t_override();
    exp_app = AUTO_TIMING;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, i, 32'hFFFF_FFE0 + i);
      apb(1'b0, i, 32'h0);
      chk("override read", 32'hE0 + i, rd);
      exp_app[34-7*i -: 7] = 7'h60 + i;
      @(negedge CLK_SYS);
      chk("override applied", exp_app, APPLIED_TIMING);
    end
    // overrides must ignore a moving automatic figure
    @(posedge CLK_SYS);
    AUTO_TIMING <= {7'h0A, 7'h1B, 7'h2C, 7'h3D, 7'h4E};
    repeat (3) @(negedge CLK_SYS);
    chk("override holds", exp_app, APPLIED_TIMING);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, i, 32'h0000_007F);
      apb(1'b0, i, 32'h0);
      chk("back to auto read", autoval(i), rd);
    end
    @(negedge CLK_SYS);
    chk("back to auto applied", AUTO_TIMING, APPLIED_TIMING);
  endtask : t_override
  task t_refused();
    apb(1'b0, 0, 32'h0, 32'h0000_0114);
    chk("unmapped err", 35'h1, er);
    chk("unmapped data", 35'h0, rd);
    apb(1'b1, 0, 32'h0000_00C5, 32'h0000_0101);
    chk("misaligned err", 35'h1, er);
    apb(1'b1, 0, 32'h0000_00C5, 32'h0, 4'h0);
    chk("strobe off err", 35'h0, er);
    apb(1'b0, 0, 32'h0);
    chk("no stray write", autoval(0), rd);
  endtask : t_refused
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // watchdog far beyond the roughly 140 cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    AUTO_TIMING <= {7'h11, 7'h22, 7'h33, 7'h44, 7'h55};
    repeat (16) @(posedge CLK_SYS);
    chk("applied in reset", 35'h0, APPLIED_TIMING);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    t_reset();
    t_override();
    t_refused();
    final_report();
  end
endmodule : csi_phy_timing_override_regs_tb
